/* File: inc/wssr_pkg.sv */
// Package: constants and types for the wiper store/restore controller
package wssr_pkg;
    localparam int WIPER_W = 10;
    localparam int CMD_W = 4;
    localparam int WORD_W = 16;
    localparam int MEM_DEPTH = 50;
    localparam int MEM_AW = 6;
    localparam logic [4:0] ADDR_UPPER = 5'h0B;
    localparam logic [1:0] ID_LOW_GND = 2'h3;
    localparam logic [1:0] ID_LOW_VDD = 2'h0;
    localparam logic [1:0] ID_LOW_OPEN = 2'h2;
    localparam logic [WIPER_W-1:0] WIPER_MIDSCALE = 10'h200;
    localparam logic [CMD_W-1:0] CMD_WRITE_WIPER = 4'h1;
    localparam logic [CMD_W-1:0] CMD_STORE = 4'h3;
    localparam logic [CMD_W-1:0] CMD_RESTORE = 4'h4;
    localparam int WORD_CMD_LSB = 10;
    localparam int CLK_MHZ = 200;
    localparam int STORE_TIME_MS = 350;
    localparam int STORE_CYCLES = STORE_TIME_MS * 1000 * CLK_MHZ;
    localparam int SYNC_STAGES = 3;

    // Three-level select strap decoded at the pad into two flags
    typedef struct packed {
        logic tied_gnd;
        logic tied_vdd;
    } wssr_strap_t;

    typedef struct packed {
        logic [CMD_W-1:0] cmd;
        logic [WIPER_W-1:0] data;
    } wssr_cmd_t;
endpackage

/* File: logic/wssr_mem.sv */
// Programmable wiper memory: one write port, registered read
`timescale 1ns/1ps
module wssr_mem
    import wssr_pkg::*;
#(
    parameter int DEPTH = MEM_DEPTH,
    parameter int AW = MEM_AW,
    parameter int DW = WIPER_W
) (
    // Clock
    input wire logic clk_sys,
    // Write port
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data,
    // Read port
    input wire logic [AW-1:0] rd_addr,
    output logic [DW-1:0] rd_data
);
    logic [DW-1:0] mem_q [DEPTH];

    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
        end
        rd_data <= mem_q[rd_addr];
    end
endmodule

/* File: logic/wssr_ctrl.sv */
// Wiper setting register with serial slave port, store and restore
//
// Overview of operation
// [R1] Low on the reset pin reloads the wiper from the latest stored location.
// [R2] With nothing stored yet, a restore loads midscale instead.
// [R3] Data line is driven open drain only: pull low or release.
// [R4] Bits shift under the bus clock through a 16-bit input word register.
// [R5] Low two slave id bits come from the three-level select strap.
// [R6] Wiper position output follows the wiper setting register directly.
// [R7] Wiper writes are accepted without any limit on count.
// [R8] Once stored, the stored value is restored at every later power-up.
// [R9] During a store (about 350 ms) no command is acknowledged.
// [R10] The master polls with its address until acknowledged again.
// [R11] Word is MSB first: two zero bits, four command bits, ten data bits.
// [R12] Upper id bits 01011; ground gives 11, supply 00, open 10.
// [R13] Write: address with R/W zero, then two bytes, all acknowledged.
`timescale 1ns/1ps
module wssr_ctrl
    import wssr_pkg::*;
#(
    parameter int STORE_CYC = STORE_CYCLES
) (
    // Clock and reset (sys_rst models power-up)
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Serial bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Board pins
    input wire logic hw_rst_n,
    input wire wssr_strap_t id_strap,
    // Wiper and status
    output logic [WIPER_W-1:0] wiper_pos,
    output logic store_busy,
    output logic [MEM_AW-1:0] mem_used
);
    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ACK, ST_DATA, ST_IGNORE} wssr_state_t;

    // Three-stage synchronisers; second and third stages must agree
    logic [SYNC_STAGES-1:0] scl_s_q, sda_s_q, rst_s_q;
    logic scl_q, sda_q, rst_n_q;
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            scl_s_q <= '1;
            sda_s_q <= '1;
            rst_s_q <= '1;
        end else begin
            scl_s_q <= {scl_s_q[1:0], scl_in};
            sda_s_q <= {sda_s_q[1:0], sda_in};
            rst_s_q <= {rst_s_q[1:0], hw_rst_n};
        end
    end

    function automatic logic filt(input logic [SYNC_STAGES-1:0] s, input logic prev);
        filt = (s[1] == s[2]) ? s[2] : prev;
    endfunction

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            rst_n_q <= 1'b1;
        end else begin
            scl_q <= filt(scl_s_q, scl_q);
            sda_q <= filt(sda_s_q, sda_q);
            rst_n_q <= filt(rst_s_q, rst_n_q);
        end
    end

    wire scl_now = filt(scl_s_q, scl_q);
    wire sda_now = filt(sda_s_q, sda_q);
    wire rst_now = filt(rst_s_q, rst_n_q);
    wire scl_rise = scl_now & ~scl_q;
    wire scl_fall = ~scl_now & scl_q;
    wire start_ev = scl_q & scl_now & sda_q & ~sda_now;
    wire stop_ev = scl_q & scl_now & ~sda_q & sda_now;
    wire hw_rst_fall = rst_n_q & ~rst_now;

    // Slave address from strap; the open level is neither flag [R5]
    wire [1:0] id_low = id_strap.tied_gnd ? ID_LOW_GND :
                        id_strap.tied_vdd ? ID_LOW_VDD : ID_LOW_OPEN; // [R12]
    wire [6:0] my_addr = {ADDR_UPPER, id_low}; // [R12]

    // Byte engine
    wssr_state_t st_q, st_d;
    logic [3:0] bit_q;
    logic [7:0] byte_q;
    logic [WORD_W-1:0] word_q;
    logic byte_idx_q;
    logic ack_drive_q;
    logic store_go, restore_go;
    logic [31:0] busy_cnt_q;
    logic busy_q;

    wire byte_done = scl_fall & (bit_q == 4'd8);
    wire [7:0] byte_full = byte_q;
    wire addr_hit = (byte_full[7:1] == my_addr) & ~byte_full[0]; // [R13]
    wire [WORD_W-1:0] word_next = {word_q[7:0], byte_full}; // [R4] [R11]
    wssr_cmd_t cmd_in;
    assign cmd_in = '{cmd: word_next[WORD_CMD_LSB +: CMD_W], data: word_next[WIPER_W-1:0]};
    // A store started earlier in the same transfer locks out later words [R9]
    wire word_done = (st_q == ST_DATA) & byte_done & byte_idx_q & ~busy_q;

    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_IDLE: st_d = st_q;
            ST_ADDR: begin
                if (byte_done) begin
                    // Locked during a store: no ack so the master polls [R9] [R10]
                    st_d = (addr_hit && !busy_q) ? ST_ACK : ST_IGNORE;
                end
            end
            ST_ACK: if (scl_fall) st_d = ST_DATA;
            ST_DATA: if (byte_done) st_d = busy_q ? ST_IGNORE : ST_ACK; // [R9]
            ST_IGNORE: st_d = st_q;
            default: st_d = ST_IDLE;
        endcase
        if (start_ev) begin
            st_d = ST_ADDR;
        end else if (stop_ev) begin
            st_d = ST_IDLE;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st_q <= ST_IDLE;
            bit_q <= 4'd0;
            byte_q <= 8'h00;
            word_q <= '0;
            byte_idx_q <= 1'b0;
            ack_drive_q <= 1'b0;
        end else begin
            st_q <= st_d;
            if (start_ev || (st_q == ST_ACK && scl_fall)) begin
                bit_q <= 4'd0;
            end else if (scl_rise && bit_q < 4'd8) begin
                bit_q <= bit_q + 4'd1;
                byte_q <= {byte_q[6:0], sda_now}; // [R4]
            end
            if (start_ev) begin
                byte_idx_q <= 1'b0;
            end else if (st_q == ST_DATA && byte_done) begin
                byte_idx_q <= ~byte_idx_q;
                word_q <= word_next; // [R4]
            end
            // Acknowledge from the eighth fall to the ninth fall [R13]
            if (st_d == ST_ACK && byte_done) begin
                ack_drive_q <= 1'b1;
            end else if (scl_fall || start_ev || stop_ev) begin
                ack_drive_q <= 1'b0;
            end
        end
    end

    // Open drain: output always low, only the enable moves [R3]
    assign sda_out = 1'b0;
    assign sda_oe = ack_drive_q; // [R3]

    // Wiper, store and restore
    logic [WIPER_W-1:0] wiper_q;
    // Fuse count is nonvolatile: factory state is empty, sys_rst leaves it alone [R8]
    logic [MEM_AW-1:0] used_q = '0;
    logic restore_pend_q, restore_rd_q;
    logic [WIPER_W-1:0] mem_rd;
    wire write_go = word_done & (cmd_in.cmd == CMD_WRITE_WIPER); // [R7]
    assign store_go = word_done & (cmd_in.cmd == CMD_STORE) & (used_q < MEM_AW'(MEM_DEPTH));
    assign restore_go = hw_rst_fall | (word_done & (cmd_in.cmd == CMD_RESTORE)); // [R1]
    wire [MEM_AW-1:0] last_loc = used_q - MEM_AW'(1);

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            wiper_q <= WIPER_MIDSCALE;
            busy_q <= 1'b0;
            busy_cnt_q <= '0;
            restore_pend_q <= 1'b1; // Power-up restore [R8]
            restore_rd_q <= 1'b0;
        end else begin
            restore_rd_q <= restore_pend_q;
            restore_pend_q <= restore_go;
            if (restore_rd_q) begin
                wiper_q <= (used_q == '0) ? WIPER_MIDSCALE : mem_rd; // [R1] [R2] [R8]
            end else if (write_go) begin
                wiper_q <= cmd_in.data; // [R7]
            end
            if (store_go) begin
                busy_q <= 1'b1; // [R9]
                busy_cnt_q <= 32'(STORE_CYC - 1);
                used_q <= used_q + MEM_AW'(1);
            end else if (busy_q) begin
                if (busy_cnt_q == '0) begin
                    busy_q <= 1'b0;
                end else begin
                    busy_cnt_q <= busy_cnt_q - 32'd1;
                end
            end
        end
    end

    // Memory contents outlive sys_rst so a power-up restore finds them [R8]
    wssr_mem u_mem (
        .clk_sys(clk_sys),
        .wr_en(store_go),
        .wr_addr(used_q),
        .wr_data(wiper_q),
        .rd_addr(last_loc),
        .rd_data(mem_rd)
    );

    assign wiper_pos = wiper_q; // [R6]
    assign store_busy = busy_q;
    assign mem_used = used_q;

    AST_NO_ACK_BUSY: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (st_q == ST_ADDR && byte_done && busy_q) |=> !ack_drive_q) // [R9]
        else $error("ack given during store");
    AST_ACK_HIT: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (st_q == ST_ADDR && byte_done && addr_hit && !busy_q && !start_ev && !stop_ev)
        |=> sda_oe) // [R13]
        else $error("address not acknowledged");
    AST_WRITE: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (write_go && !restore_rd_q) |=> wiper_pos == $past(cmd_in.data)) // [R7]
        else $error("wiper write lost");
    AST_RESTORE_MID: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (hw_rst_fall && used_q == '0 && !store_go) |-> ##3 wiper_pos == WIPER_MIDSCALE) // [R2]
        else $error("midscale restore failed");
    AST_RESTORE: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (restore_rd_q && used_q != '0) |=> wiper_pos == $past(mem_rd)) // [R1]
        else $error("restore value wrong");
    AST_BUSY_START: assert property (@(posedge clk_sys) disable iff (sys_rst)
        store_go |=> store_busy) // [R9]
        else $error("store did not lock");
    AST_OD: assert property (@(posedge clk_sys) sda_out == 1'b0) // [R3]
        else $error("data line driven high");
    AST_ID: assert property (@(posedge clk_sys) disable iff (sys_rst)
        id_strap.tied_gnd |-> my_addr == 7'h2F) // [R12]
        else $error("address strap decode wrong");
    AST_POWERUP: assert property (@(posedge clk_sys)
        $fell(sys_rst) |-> ##1 restore_rd_q) // [R8]
        else $error("no power-up restore");
    AST_WIPER: assert property (@(posedge clk_sys) disable iff (sys_rst)
        wiper_pos == $past(wiper_pos) ||
        $past(write_go) || $past(restore_rd_q) || $past(sys_rst)) // [R6]
        else $error("wiper moved without cause");

    COV_WRITE: cover property (@(posedge clk_sys) write_go);
    COV_STORE: cover property (@(posedge clk_sys) store_go);
    COV_NACK: cover property (@(posedge clk_sys) st_q == ST_ADDR && byte_done && busy_q);
    COV_HWRST: cover property (@(posedge clk_sys) hw_rst_fall && used_q != '0);
endmodule

/* File: testbench/wssr_master.sv */
// Bus master model: drives the clock line and the open-drain data line
`timescale 1ns/1ps
module wssr_master (
    // Clock
    input wire logic clk_sys,
    // Bus lines
    output logic scl,
    output logic sda_rel,
    input wire logic sda
);
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end
    task automatic half();
        repeat (10) @(posedge clk_sys);
    endtask
    // Data moves a few cycles after the clock falls so no false start or stop is seen
    task automatic bit_out(input logic b, output logic s);
        repeat (3) @(posedge clk_sys);
        sda_rel <= b;
        half();
        scl <= 1'b1;
        half();
        s = sda;
        scl <= 1'b0;
    endtask
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_out(b[i], s);
        end
        bit_out(1'b1, s);
        ack = ~s;
    endtask
    // A refused address ends the transfer, which also serves as a poll
    task automatic write_word(input logic [6:0] a, input logic [15:0] w, output logic [2:0] ack);
        ack = 3'h0;
        sda_rel <= 1'b0;
        half();
        scl <= 1'b0;
        send_byte({a, 1'b0}, ack[2]);
        if (ack[2]) begin
            send_byte(w[15:8], ack[1]);
            send_byte(w[7:0], ack[0]);
        end
        half();
        sda_rel <= 1'b0;
        half();
        scl <= 1'b1;
        half();
        sda_rel <= 1'b1;
        half();
    endtask
endmodule

/* File: testbench/testbench.sv */
// Self-checking bench for the wiper store/restore controller
`timescale 1ns/1ps
module testbench;
    import wssr_pkg::*;
    logic clk_sys;
    logic sys_rst;
    logic hw_rst_n;
    wssr_strap_t id_strap;
    logic scl;
    logic sda_rel;
    logic sda_out;
    logic sda_oe;
    logic store_busy;
    logic [WIPER_W-1:0] wiper_pos;
    logic [MEM_AW-1:0] mem_used;
    logic [2:0] ack;
    int fail_count = 0;
    int total_checks = 0;
    int cycles = 0;
    // Pull-up on the data line; the device may only pull it low
    wire sda = sda_rel & ~(sda_oe & ~sda_out);

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // Short store time so the lock can be polled within the run
    wssr_ctrl #(.STORE_CYC(400)) i_wssr_ctrl (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .hw_rst_n(hw_rst_n), .id_strap(id_strap),
        .wiper_pos(wiper_pos), .store_busy(store_busy), .mem_used(mem_used));
    wssr_master i_wssr_master (.clk_sys(clk_sys), .scl(scl), .sda_rel(sda_rel), .sda(sda));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] c, input logic [9:0] d);
        i_wssr_master.write_word({ADDR_UPPER, ID_LOW_GND}, {2'b00, c, d}, ack);
    endtask
    task automatic hw_reset();
        hw_rst_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        hw_rst_n <= 1'b1;
        repeat (20) @(posedge clk_sys);
    endtask

    task automatic t_power_up();
        chk(16'(wiper_pos), 16'h0200);
        chk(16'(mem_used), 16'h0000);
        wr(CMD_WRITE_WIPER, 10'h111);
        hw_reset();
        chk(16'(wiper_pos), 16'h0200);
        $display("test power_up done");
    endtask
    task automatic t_write();
        logic [9:0] v[4] = '{10'h1FF, 10'h000, 10'h3FF, 10'h155};
        for (int i = 0; i < 4; i++) begin
            wr(CMD_WRITE_WIPER, v[i]);
            chk(16'(ack), 16'h0007);
            chk(16'(wiper_pos), 16'(v[i]));
        end
        $display("test write done");
    endtask
    task automatic t_addr();
        logic [1:0] s[3] = '{2'b10, 2'b01, 2'b00};
        logic [1:0] lo[3] = '{ID_LOW_GND, ID_LOW_VDD, ID_LOW_OPEN};
        for (int i = 0; i < 3; i++) begin
            id_strap <= wssr_strap_t'(s[i]);
            @(posedge clk_sys);
            i_wssr_master.write_word({ADDR_UPPER, lo[i]}, {6'h01, 10'(i + 1)}, ack);
            chk(16'(ack), 16'h0007);
            i_wssr_master.write_word({ADDR_UPPER, ~lo[i]}, 16'h07FF, ack);
            chk(16'(ack), 16'h0000);
            chk(16'(wiper_pos), 16'(i + 1));
        end
        id_strap <= wssr_strap_t'(2'b10);
        $display("test addr done");
    endtask
    task automatic t_store();
        wr(CMD_WRITE_WIPER, 10'h0AB);
        wr(CMD_STORE, 10'h000);
        chk(16'(ack), 16'h0007);
        chk(16'(store_busy), 16'h0001);
        wr(CMD_WRITE_WIPER, 10'h055);
        chk(16'(ack), 16'h0000);
        chk(16'(wiper_pos), 16'h00AB);
        for (int n = 0; n < 10 && ack !== 3'h7; n++) begin
            wr(CMD_WRITE_WIPER, 10'h0AB);
        end
        chk(16'(ack), 16'h0007);
        chk(16'(mem_used), 16'h0001);
        $display("test store done");
    endtask
    task automatic t_restore();
        wr(CMD_WRITE_WIPER, 10'h123);
        hw_reset();
        chk(16'(wiper_pos), 16'h00AB);
        wr(CMD_WRITE_WIPER, 10'h300);
        wr(CMD_RESTORE, 10'h000);
        repeat (10) @(posedge clk_sys);
        chk(16'(wiper_pos), 16'h00AB);
        // Second power-up while the bus is idle: the stored value must come back
        sys_rst <= 1'b1;
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (8) @(posedge clk_sys);
        chk(16'(wiper_pos), 16'h00AB);
        chk(16'(mem_used), 16'h0001);
        $display("test restore done");
    endtask

    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            fail_count++;
            finish_test();
        end
    end

    initial begin
        sys_rst = 1'b1;
        hw_rst_n = 1'b1;
        id_strap = wssr_strap_t'(2'b10);
        repeat (10) @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (8) @(posedge clk_sys);
        t_power_up();
        t_write();
        t_addr();
        t_store();
        t_restore();
        finish_test();
    end
endmodule
